// ### hw/abt_arbiter.sv
// arbiter bit timer with apb register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
module abt_arbiter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [abt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxLine,
    input wire logic prescTick,
    input wire logic internalTransmitOutput,
    output logic txPin,
    output logic irq
);
    import abt_pkg::*;

    abt_state_t state_ff;
    abt_state_t nxt_state;
    logic [1:0] mode_ff;
    logic clkSel_ff;
    logic lost_ff;
    logic fin_ff;
    logic ovf_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic sampled_ff;
    logic rxLowSeen_ff;
    logic rxPrev_ff;
    logic txPrev_ff;
    logic [IRQ_W-1:0] stat_ff;
    logic [IRQ_W-1:0] mask_ff;
    logic [31:0] rdata_ff;
    logic rxS;
    logic tick;
    logic mapped;
    logic acc;
    logic ctrlWr;
    logic rxFall;
    logic rxRise;
    logic txRise;
    logic txFall;
    logic modeMeas;
    logic modeArb;
    logic running;
    logic cntClear;
    logic cntWrap;
    logic samplePt;
    logic lostSet;
    logic finSet;
    logic [IRQ_W-1:0] events;

    // rx is only looked at through its synchronised copy
    abt_sync u_rxSync (
        .clk(clk),
        .resetn(resetn),
        .din(rxLine),
        .dout(rxS)
    );

    abt_tick u_tick (
        .clk(clk),
        .resetn(resetn),
        .clkSel(clkSel_ff),
        .prescTick(prescTick),
        .tick(tick)
    );

    // apb decode; zero wait states, unmapped offsets answer with an error
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_DATA) ||
                    (paddr == ADDR_STAT) || (paddr == ADDR_MASK);
    assign acc = psel & penable;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = rdata_ff;
    assign ctrlWr = acc & pwrite & (paddr == ADDR_CTRL);

    // edge and mode decode
    assign rxFall = rxPrev_ff & ~rxS;
    assign rxRise = ~rxPrev_ff & rxS;
    assign txRise = ~txPrev_ff & internalTransmitOutput;
    assign txFall = txPrev_ff & ~internalTransmitOutput;
    assign modeMeas = (mode_ff == MODE_MEAS);
    assign modeArb = (mode_ff == MODE_ARB);
    assign running = (state_ff == ST_RUN);
    assign cntWrap = running & tick & (cnt_ff == CNT_MAX);
    assign samplePt = clkSel_ff ? (cnt_ff == SAMPLE_PRESC) :
                                  (cnt_ff == SAMPLE_BUS);
    assign lostSet = modeArb & running & samplePt & ~sampled_ff &
                     ~rxS & ~ctrlWr;
    assign finSet = modeMeas & running & (nxt_state == ST_STOP);
    assign events[I_FIN] = finSet;
    assign events[I_OVF] = cntWrap;
    assign events[I_LOST] = lostSet;

    // next state of the counter sequencer
    always_comb begin
        nxt_state = state_ff;
        if (ctrlWr) begin
            if (pwdata[B_MODE_HI:B_MODE_LO] == MODE_MEAS ||
                pwdata[B_MODE_HI:B_MODE_LO] == MODE_ARB) begin
                nxt_state = ST_WAIT;
            end else begin
                nxt_state = ST_IDLE;
            end
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (modeMeas || modeArb) begin
                        nxt_state = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (modeArb) begin
                        if (txRise) begin
                            nxt_state = ST_RUN;
                        end
                    end else if (modeMeas) begin
                        if (clkSel_ff ? ~rxS : rxFall) begin
                            nxt_state = ST_RUN;
                        end
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
                ST_RUN: begin
                    if (modeArb) begin
                        if (txFall && !rxLowSeen_ff && rxS) begin
                            nxt_state = ST_WAIT;
                        end
                    end else if (modeMeas) begin
                        if (clkSel_ff ? rxRise : rxFall) begin
                            nxt_state = ST_STOP;
                        end
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
                ST_STOP: begin
                    if (!modeMeas) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // counter restarts on entry to run and on each transmit rise in arbitration mode
    assign cntClear = ctrlWr || (mode_ff == MODE_IDLE) ||
                      (nxt_state == ST_RUN && !running) ||
                      (modeArb && running && txRise) ||
                      (nxt_state == ST_WAIT);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // nine-bit counter, wraps freely; overflow is caught in its own flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_ff <= CNT_ZERO;
        end else if (cntClear) begin
            cnt_ff <= CNT_ZERO;
        end else if (running && tick) begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end

    // control fields written by software
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_ff <= MODE_IDLE;
            clkSel_ff <= 1'b0;
        end else if (ctrlWr) begin
            mode_ff <= pwdata[B_MODE_HI:B_MODE_LO];
            clkSel_ff <= pwdata[B_CLKSEL];
        end
    end

    // sticky status flags; hardware set wins over the write clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fin_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            if (finSet) begin
                fin_ff <= 1'b1;
            end else if (ctrlWr) begin
                fin_ff <= 1'b0;
            end
            if (cntWrap) begin
                ovf_ff <= 1'b1;
            end else if (ctrlWr) begin
                ovf_ff <= 1'b0;
            end
        end
    end

    // lost flag: only a write with upper mode bit 0 clears it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lost_ff <= 1'b0;
        end else if (lostSet) begin
            lost_ff <= 1'b1;
        end else if (ctrlWr && !pwdata[B_MODE_HI]) begin
            lost_ff <= 1'b0;
        end
    end

    // one sample per bit, and memory of any rx low during the bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sampled_ff <= 1'b0;
            rxLowSeen_ff <= 1'b0;
        end else if (cntClear) begin
            sampled_ff <= 1'b0;
            rxLowSeen_ff <= 1'b0;
        end else begin
            if (modeArb && running && samplePt) begin
                sampled_ff <= 1'b1;
            end
            // our own low from before the rise still sits in the
            // synchroniser while the count is zero, so it is not foreign
            if (modeArb && running && !rxS && cnt_ff != CNT_ZERO) begin
                rxLowSeen_ff <= 1'b1;
            end
        end
    end

    // edge history of synchronised rx and internal transmit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxPrev_ff <= 1'b1;
            txPrev_ff <= 1'b1;
        end else begin
            rxPrev_ff <= rxS;
            txPrev_ff <= internalTransmitOutput;
        end
    end

    // interrupt status (write one to clear, set wins) and mask
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_ff <= '0;
            mask_ff <= '0;
        end else begin
            if (acc && pwrite && paddr == ADDR_STAT) begin
                stat_ff <= (stat_ff & ~pwdata[IRQ_W-1:0]) | events;
            end else begin
                stat_ff <= stat_ff | events;
            end
            if (acc && pwrite && paddr == ADDR_MASK) begin
                mask_ff <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_ff <= 32'h0000_0000;
            case (paddr)
                ADDR_CTRL: begin
                    rdata_ff[B_MODE_HI:B_MODE_LO] <= mode_ff;
                    rdata_ff[B_LOST] <= lost_ff;
                    rdata_ff[B_CLKSEL] <= clkSel_ff;
                    rdata_ff[B_FIN] <= fin_ff;
                    rdata_ff[B_RUN] <= running;
                    rdata_ff[B_OVF] <= ovf_ff;
                    rdata_ff[B_MSB] <= cnt_ff[CNT_W-1];
                end
                ADDR_DATA: begin
                    rdata_ff[CNT_W-2:0] <= cnt_ff[CNT_W-2:0];
                end
                ADDR_STAT: rdata_ff[IRQ_W-1:0] <= stat_ff;
                ADDR_MASK: rdata_ff[IRQ_W-1:0] <= mask_ff;
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // lost arbitration seizes the line by holding it recessive
    assign txPin = lost_ff | internalTransmitOutput;
    assign irq = |(stat_ff & mask_ff);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    idle_holds_zero_a: assert property (
        (mode_ff == MODE_IDLE) |=> (cnt_ff == CNT_ZERO) && !running)
        else $error("counter not held in idle mode");
    ctrl_write_clears_a: assert property (
        ctrlWr |=> (cnt_ff == CNT_ZERO) && (fin_ff == $past(finSet)))
        else $error("control write did not clear counter");
    ovf_on_wrap_a: assert property (
        cntWrap |=> ovf_ff && (cnt_ff == CNT_ZERO))
        else $error("wrap without overflow flag");
    ovf_sticky_a: assert property (
        ovf_ff && !ctrlWr |=> ovf_ff)
        else $error("overflow flag dropped without write");
    lost_clear_a: assert property (
        $fell(lost_ff) |-> $past(ctrlWr) && !$past(pwdata[B_MODE_HI]))
        else $error("lost flag cleared without mode write");
    tx_forced_a: assert property (
        lost_ff |-> txPin)
        else $error("transmit pin not forced while lost");
    lost_cause_a: assert property (
        $rose(lost_ff) |-> $past(modeArb) && !$past(rxS) &&
        $past(samplePt))
        else $error("lost flag set outside sample point");
    meas_stop_a: assert property (
        modeMeas && running && !clkSel_ff && rxFall && !ctrlWr
        |=> fin_ff && !running)
        else $error("measurement did not stop on falling edge");
    break_start_a: assert property (
        modeMeas && (state_ff == ST_WAIT) && clkSel_ff && !rxS && !ctrlWr
        |=> running ##1 (cnt_ff <= 9'h001))
        else $error("break measurement did not start on low rx");
    count_step_a: assert property (
        running && tick && !cntClear |=> cnt_ff == $past(cnt_ff) + 9'h001)
        else $error("counter did not step on tick");
    tx_rise_restart_a: assert property (
        modeArb && running && txRise && !ctrlWr
        |=> running && (cnt_ff == CNT_ZERO))
        else $error("counter did not restart on transmit rise");
    tx_fall_wait_a: assert property (
        modeArb && running && txFall && !rxLowSeen_ff && rxS && !ctrlWr
        |=> (state_ff == ST_WAIT) && (cnt_ff == CNT_ZERO))
        else $error("transmit fall without rx low did not wait");

    meas_done_c: cover property (modeMeas && running ##[1:300] fin_ff);
    arb_lost_c: cover property (modeArb && running ##[1:300] lost_ff);
    ovf_c: cover property (cntWrap);
    break_run_c: cover property (modeMeas && clkSel_ff && running ##1 !running);
    arb_wait_c: cover property (modeArb && running ##1 (state_ff == ST_WAIT));
endmodule

// ### hw/abt_pkg.sv
package abt_pkg;
    localparam int CNT_W = 9;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0c;
    // control register field positions
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_LOST = 5;
    localparam int B_CLKSEL = 4;
    localparam int B_FIN = 3;
    localparam int B_RUN = 2;
    localparam int B_OVF = 1;
    localparam int B_MSB = 0;
    // interrupt status/mask positions
    localparam int IRQ_W = 3;
    localparam int I_FIN = 0;
    localparam int I_OVF = 1;
    localparam int I_LOST = 2;
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEAS = 2'h1;
    localparam logic [1:0] MODE_ARB = 2'h2;
    localparam logic [CNT_W-1:0] CNT_MAX = 9'h1ff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] SAMPLE_BUS = 9'h038;
    localparam logic [CNT_W-1:0] SAMPLE_PRESC = 9'h008;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_RUN = 4'b0100,
        ST_STOP = 4'b1000
    } abt_state_t;
endpackage

// ### hw/abt_sync.sv
// two-flop synchroniser for one level
module abt_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;
    // first flop feeds only the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule

// ### hw/abt_tick.sv
// counter clock enable: bus clock / 4 or half of prescaler ticks
module abt_tick (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkSel,
    input wire logic prescTick,
    output logic tick
);
    import abt_pkg::*;
    logic [1:0] div_ff;
    logic half_ff;
    // free-running divider, so tick phase is independent of start
    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end
    // halve the prescaler tick rate
    always_ff @(posedge clk) begin
        if (!resetn) begin
            half_ff <= 1'b0;
        end else if (prescTick) begin
            half_ff <= ~half_ff;
        end
    end
    assign tick = clkSel ? (prescTick & half_ff) : (div_ff == DIV4_LAST);
endmodule

// ### bench/abt_bus_node.sv
// another node on the shared single-wire bus, plus the prescaler pulse
module abt_bus_node #(
    parameter int PRESC_DIV = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic txPin,
    input wire logic pullLow,
    output logic rxLine,
    output logic prescTick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] divCnt;
    // wired-and with pull-up: recessive high unless some node pulls low
    assign rxLine = txPin & ~pullLow;
    // free running divider, so tick phase is unrelated to bench events
    always_ff @(posedge clk) begin
        if (!resetn || divCnt == 4'(PRESC_DIV - 1)) begin
            divCnt <= 4'h0;
        end else begin
            divCnt <= divCnt + 4'h1;
        end
    end
    assign prescTick = (divCnt == 4'(PRESC_DIV - 1));
endmodule

// ### bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import abt_pkg::*;
    localparam int PRESC_DIV = 3;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxLine;
    logic prescTick;
    logic internalTransmitOutput = 1'b1;
    logic txPin;
    logic irq;
    logic pullLow = 1'b0;
    logic [31:0] rdData;
    logic rdErr;
    logic [31:0] cnt;
    logic [15:0] lfsrQ = 16'h09b2;
    int numErrors = 0;
    int numChecks = 0;

    abt_arbiter abt_arbiter_i (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxLine(rxLine), .prescTick(prescTick),
        .internalTransmitOutput(internalTransmitOutput), .txPin(txPin),
        .irq(irq));
    abt_bus_node #(.PRESC_DIV(PRESC_DIV)) abt_bus_node_i (.clk(clk),
        .resetn(resetn), .txPin(txPin), .pullLow(pullLow),
        .rxLine(rxLine), .prescTick(prescTick));

    always #10 clk = ~clk;

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // clk cycles per counter step for a clock select value
    function automatic int ticks(input logic s);
        return s ? 2 * PRESC_DIV : 4;
    endfunction

    task automatic results();
        if (numErrors == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            numErrors++;
        end
    endtask
    // counts may shift by a step with divider phase and synchroniser
    task automatic chkr(input string nm, input logic [31:0] seen,
                        input int lo, input int hi);
        numChecks++;
        if ($isunknown(seen) || seen < lo || seen > hi) begin
            $display("BAD %s expected %0d..%0d seen %h", nm, lo, hi, seen);
            numErrors++;
        end
    endtask
    // one apb transfer; the leading edge keeps strobes from double drive
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) numErrors++;
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdCnt();
        apb(1'b0, ADDR_CTRL, 32'h0);
        cnt = {23'h0, rdData[B_MSB], 8'h00};
        apb(1'b0, ADDR_DATA, 32'h0);
        cnt[7:0] = rdData[7:0];
    endtask
    task automatic fallPulse();
        pullLow <= 1'b1;
        repeat (5) @(posedge clk);
        pullLow <= 1'b0;
    endtask
    // select-0 measurement over p clocks between two falls, irq path too
    task automatic meas0(input int p);
        apb(1'b1, ADDR_STAT, 32'h7);
        apb(1'b1, ADDR_MASK, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h40);
        repeat (6) @(posedge clk);
        fallPulse();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("running", rdData[B_RUN], 32'h1);
        repeat (p - 8) @(posedge clk);
        fallPulse();
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("finished", rdData[B_FIN], 32'h1);
        chk("stopped", rdData[B_RUN], 32'h0);
        rdCnt();
        chkr("count sel0", cnt, p / 4 - 1, p / 4 + 1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("fin status", rdData[I_FIN], 32'h1);
        @(negedge clk);
        chk("irq masked", irq, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h1);
        @(negedge clk);
        chk("irq on", irq, 32'h1);
        apb(1'b1, ADDR_STAT, 32'h1);
        @(negedge clk);
        chk("irq cleared", irq, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h40);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("fin clear", rdData[B_FIN], 32'h0);
        rdCnt();
        chk("count clear", cnt, 32'h0);
    endtask
    // arbitration with another node dominant after the transmit rise
    task automatic arb(input logic s);
        int smp;
        smp = s ? SAMPLE_PRESC : SAMPLE_BUS;
        internalTransmitOutput <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h7);
        apb(1'b1, ADDR_CTRL, s ? 32'h90 : 32'h80);
        @(posedge clk);
        internalTransmitOutput <= 1'b1;
        repeat (10) @(posedge clk);
        pullLow <= 1'b1;
        repeat (smp * ticks(s) * 3 / 4 - 13) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("lost early", rdData[B_LOST], 32'h0);
        repeat (smp * ticks(s) / 2) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("lost set", rdData[B_LOST], 32'h1);
        internalTransmitOutput <= 1'b0;
        @(negedge clk);
        chk("tx seized", txPin, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h80);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("lost kept", rdData[B_LOST], 32'h1);
        pullLow <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("lost clear", rdData[B_LOST], 32'h0);
        @(negedge clk);
        chk("tx free", txPin, 32'h0);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        numErrors++;
        results();
    end

    initial begin
        int n;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(4 * a), 32'h0);
            chk("reset value", rdData, 32'h0);
            chk("slave error", rdErr, (a == 4) ? 32'h1 : 32'h0);
        end
        // mode and clock select read back, select drawn at random
        for (int m = 0; m < 3; m++) begin
            lfsrQ = lfsrNext(lfsrQ);
            apb(1'b1, ADDR_CTRL, {24'h0, 2'(m), 1'b0, lfsrQ[0], 4'h0});
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk("mode rw", rdData & 32'hd0,
                {24'h0, 2'(m), 1'b0, lfsrQ[0], 4'h0});
        end
        meas0(1100);
        repeat (2) begin
            lfsrQ = lfsrNext(lfsrQ);
            meas0(40 + int'(lfsrQ % 16'h0169));
        end
        // select 1: line already low when measurement is enabled
        lfsrQ = lfsrNext(lfsrQ);
        n = 40 + int'(lfsrQ % 16'h0078);
        pullLow <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, ADDR_CTRL, 32'h50);
        repeat (n) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("run sel1", rdData[B_RUN], 32'h1);
        pullLow <= 1'b0;
        repeat (8) @(posedge clk);
        rdCnt();
        // run spans n + 5 clocks: write, read and both synchroniser lags
        chkr("count sel1", cnt, (n + 5) / ticks(1'b1) - 1,
             (n + 5) / ticks(1'b1) + 1);
        // long run after a single fall wraps the counter
        apb(1'b1, ADDR_CTRL, 32'h40);
        fallPulse();
        repeat (2100) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("overflow", rdData[B_OVF], 32'h1);
        chk("still run", rdData[B_RUN], 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("ovf status", rdData[I_OVF], 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h40);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ovf clear", rdData[B_OVF], 32'h0);
        // idle mode ignores the line
        apb(1'b1, ADDR_CTRL, 32'h0);
        fallPulse();
        repeat (40) @(posedge clk);
        fallPulse();
        rdCnt();
        chk("idle count", cnt, 32'h0);
        arb(1'b0);
        arb(1'b1);
        // arbitration with a quiet bus never loses
        apb(1'b1, ADDR_CTRL, 32'h80);
        internalTransmitOutput <= 1'b1;
        repeat (300) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("no loss", rdData[B_LOST], 32'h0);
        // own transmit fall with no foreign low goes back to waiting
        internalTransmitOutput <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("arb wait", rdData[B_RUN], 32'h0);
        rdCnt();
        chk("arb reset", cnt, 32'h0);
        internalTransmitOutput <= 1'b1;
        repeat (20) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("arb rerun", rdData[B_RUN], 32'h1);
        results();
    end
endmodule
